//--- design/fpas_pkg.sv
// Constants and types for the fixed-point add/subtract datapath.
// Assumes one 125 MHz clock shared by the register-port master and the memory port.
package fpas_pkg;

	// ==========================================================
	// Register map (byte offsets, one word each)
	localparam logic [7:0] FPAS_REG_GPR_BASE = 8'h00;
	localparam logic [7:0] FPAS_REG_PSW = 8'h20;
	localparam logic [7:0] FPAS_REG_INSTR = 8'h24;
	localparam logic [7:0] FPAS_REG_EADDR = 8'h28;
	localparam logic [7:0] FPAS_REG_CTRL = 8'h2C;
	localparam logic [7:0] FPAS_REG_STAT = 8'h30;
	localparam logic [7:0] FPAS_REG_IRQ_STS = 8'h34;
	localparam logic [7:0] FPAS_REG_IRQ_MASK = 8'h38;

	// ==========================================================
	// Field positions
	localparam int FPAS_OVF_FLAG_POS = 30;
	localparam int FPAS_ZERO_FLAG_POS = 27;
	localparam int FPAS_PC_MSB = 23;
	localparam int FPAS_OPC_HI = 31;
	localparam int FPAS_OPC_LO = 26;
	localparam int FPAS_RD_HI = 25;
	localparam int FPAS_RD_LO = 23;
	localparam int FPAS_RS_HI = 22;
	localparam int FPAS_RS_LO = 20;
	localparam int FPAS_FBIT_POS = 19;
	localparam int FPAS_SUBOP_HI = 18;
	localparam int FPAS_SUBOP_LO = 16;
	localparam int FPAS_IMM_HI = 15;
	localparam int FPAS_CTRL_START_POS = 0;
	localparam int FPAS_IRQ_DONE_POS = 0;
	localparam int FPAS_IRQ_OVF_POS = 1;
	localparam int FPAS_IRQ_ILL_POS = 2;
	localparam int FPAS_IRQ_W = 3;

	// ==========================================================
	// Encodings, steps and reset values
	localparam logic [5:0] FPAS_OPC_RR = 6'h0E;
	localparam logic [5:0] FPAS_OPC_ARM = 6'h3A;
	localparam logic [5:0] FPAS_OPC_SUM = 6'h2F;
	localparam logic [5:0] FPAS_OPC_IMM = 6'h32;
	localparam logic [2:0] FPAS_SUBOP_ADD_IMM = 3'h1;
	localparam logic [1:0] FPAS_SZ_WORD = 2'h0;
	localparam logic [1:0] FPAS_SZ_HALF = 2'h1;
	localparam logic [1:0] FPAS_SZ_DOUBLE = 2'h2;
	localparam logic [2:0] FPAS_MASK_IDX = 3'h4;
	localparam logic [23:0] FPAS_PC_STEP_SHORT = 24'h000002;
	localparam logic [23:0] FPAS_PC_STEP_LONG = 24'h000004;
	localparam logic [31:0] FPAS_PSW_RST = 32'h00000000;
	localparam logic [2:0] FPAS_IRQ_MASK_RST = 3'h0;

	// ==========================================================
	// Types
	typedef enum logic [5:0] {S_IDLE = 6'h01, S_READ = 6'h02, S_WAIT = 6'h04,
		S_EXEC = 6'h08, S_WRITE = 6'h10, S_FIN = 6'h20} fpas_fsm_type;
	typedef enum logic [3:0] {OP_NONE = 4'h0, OP_RR = 4'h1, OP_RRM = 4'h2, OP_ARB = 4'h3, OP_ARH = 4'h4,
		OP_ARW = 4'h5, OP_ARD = 4'h6, OP_ADD_IMM = 4'h7, OP_SMB = 4'h8, OP_SMH = 4'h9, OP_ILL = 4'hF} fpas_op_type;
	typedef struct packed {logic wr; logic rd; logic [7:0] addr; logic [31:0] wdata;} fpas_bus_req_type;
	typedef struct packed {logic wr; logic rd; logic [23:0] addr; logic [31:0] wdata; logic [3:0] be;} fpas_mem_req_type;
	typedef struct packed {logic rvalid; logic [31:0] rdata;} fpas_mem_rsp_type;
	typedef struct packed {
		fpas_fsm_type state;
		fpas_op_type op;
		logic [7:0][31:0] general_register;
		logic [31:0] psw;
		logic [31:0] instr;
		logic [23:0] eaddr;
		logic [31:0] mdata_hi;
		logic [31:0] mdata_lo;
		logic wsel;
		fpas_mem_req_type mem;
		logic [31:0] rdata;
		logic [2:0] sts;
		logic [2:0] mask;
		logic irq;
		logic busy;
	} fpas_state_type;

	localparam fpas_state_type FPAS_ST_RST = '{state: S_IDLE, op: OP_NONE, psw: FPAS_PSW_RST,
		mask: FPAS_IRQ_MASK_RST, default: '0};

endpackage : fpas_pkg

//--- design/fpas_top.sv
// Fixed-point add/subtract datapath with its own general register file and status word.
// Assumes a same-clock master on the register port and a memory that answers reads with rvalid
// and takes one write per cycle without stalling.
// Functional notes
// - Register-to-register add puts destination plus source into the destination register.
// - The masked register add ANDs the sum with register four before writing the destination.
// - Full-width results set overflow, positive, negative and zero condition bits.
// - Add to memory byte adds the byte to the register and stores only the low result byte.
// - Add to memory byte leaves the register and the other three bytes of the word alone.
// - After add to memory byte only the zero bit is meaningful, taken from the whole 32-bit sum.
// - Add to memory halfword adds the halfword to register bits 0-15 and stores it back.
// - Add to memory halfword leaves the other halfword of the word alone.
// - After add to memory halfword the zero bit reflects the stored halfword.
// - Add to memory word stores the 32-bit sum to memory and leaves the register unchanged.
// - Add to memory doubleword adds odd register to low word first, then even plus carry to high.
// - Doubleword condition bits come from the whole 64-bit stored result.
// - Add immediate sign-extends the low instruction halfword and adds it to the register.
// - Subtract memory byte zero-extends the byte and subtracts it from the register.
// - Subtract memory halfword sign-extends the halfword and subtracts it from the register.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module fpas_top (
	input wire logic I_SYS_CLK,
	input wire logic I_ARST_N,
	input wire fpas_pkg::fpas_bus_req_type I_BUS_REQ,
	output logic [31:0] O_BUS_RDATA,
	output fpas_pkg::fpas_mem_req_type O_MEM_REQ,
	input wire fpas_pkg::fpas_mem_rsp_type I_MEM_RSP,
	output logic O_IRQ,
	output logic O_BUSY
);
	import fpas_pkg::*;

	fpas_state_type st_ff;
	fpas_state_type nxt_st;
	fpas_op_type dec_op;
	logic [2:0] rd_idx;
	logic [2:0] rs_idx;
	logic [2:0] even_idx;
	logic [2:0] odd_idx;
	logic [31:0] opd_a;
	logic [31:0] opd_b;
	logic [31:0] mask_val;
	logic [7:0] mem_byte;
	logic [15:0] mem_half;
	logic [15:0] imm_half;
	logic is_sub;
	logic ovf32;
	logic [31:0] res32;
	logic [31:0] masked32;
	logic [15:0] half_sum;
	logic [32:0] dbl_lo;
	logic [31:0] dbl_hi;
	logic [63:0] res64;
	logic ovf64;
	logic [23:0] pc_now;

	// Condition bits from overflow, sign and zero
	function automatic logic [3:0] fpas_cc(input logic ovf, input logic neg, input logic zero);
		fpas_cc = {ovf, ~neg & ~zero, neg, zero};
	endfunction : fpas_cc

	// ==========================================================
	// Decode
	// Operand size lives in the F bit and the two low address bits of the instruction
	always_comb
	begin
		dec_op = OP_ILL;
		case (st_ff.instr[FPAS_OPC_HI:FPAS_OPC_LO])
			FPAS_OPC_RR: dec_op = st_ff.instr[FPAS_FBIT_POS] ? OP_RRM : OP_RR;
			FPAS_OPC_ARM:
			begin
				if (st_ff.instr[FPAS_FBIT_POS])
					dec_op = OP_ARB;
				else if (st_ff.instr[1:0] == FPAS_SZ_HALF)
					dec_op = OP_ARH;
				else if (st_ff.instr[1:0] == FPAS_SZ_WORD)
					dec_op = OP_ARW;
				else if (st_ff.instr[1:0] == FPAS_SZ_DOUBLE)
					dec_op = OP_ARD;
				else
					dec_op = OP_ILL;
			end
			FPAS_OPC_SUM:
			begin
				if (st_ff.instr[FPAS_FBIT_POS])
					dec_op = OP_SMB;
				else if (st_ff.instr[1:0] == FPAS_SZ_HALF)
					dec_op = OP_SMH;
				else
					dec_op = OP_ILL; // Word and double subtract are outside this block
			end
			FPAS_OPC_IMM:
				dec_op = (st_ff.instr[FPAS_SUBOP_HI:FPAS_SUBOP_LO] == FPAS_SUBOP_ADD_IMM) ? OP_ADD_IMM : OP_ILL;
			default: dec_op = OP_ILL;
		endcase
	end

	// ==========================================================
	// Datapath
	assign rd_idx = st_ff.instr[FPAS_RD_HI:FPAS_RD_LO];
	assign rs_idx = st_ff.instr[FPAS_RS_HI:FPAS_RS_LO];
	assign even_idx = {rd_idx[2:1], 1'b0};
	assign odd_idx = {rd_idx[2:1], 1'b1};
	assign opd_a = st_ff.general_register[rd_idx];
	assign mask_val = st_ff.general_register[FPAS_MASK_IDX];
	assign pc_now = st_ff.psw[FPAS_PC_MSB:0];
	// Big-endian lanes: byte 0 of a word is bits 31:24
	assign mem_byte = st_ff.mdata_hi[{~st_ff.eaddr[1:0], 3'b000} +: 8];
	assign mem_half = st_ff.mdata_hi[{~st_ff.eaddr[1], 4'b0000} +: 16];
	assign imm_half = st_ff.instr[FPAS_IMM_HI:0];
	assign is_sub = (st_ff.op == OP_SMB) || (st_ff.op == OP_SMH);

	// Second operand shaping
	always_comb
	begin
		case (st_ff.op)
			OP_RR, OP_RRM: opd_b = st_ff.general_register[rs_idx];
			OP_ARB, OP_SMB: opd_b = {24'h000000, mem_byte};
			OP_SMH: opd_b = {{16{mem_half[15]}}, mem_half};
			OP_ADD_IMM: opd_b = {{16{imm_half[15]}}, imm_half};
			OP_ARW: opd_b = st_ff.mdata_hi;
			default: opd_b = 32'h00000000;
		endcase
	end

	assign res32 = is_sub ? (opd_a - opd_b) : (opd_a + opd_b);
	// Overflow: operands agree (add) or differ (sub) in sign and the result sign flips
	assign ovf32 = ((opd_a[31] == opd_b[31]) ^ is_sub) && (res32[31] != opd_a[31]);
	assign masked32 = res32 & mask_val;
	assign half_sum = opd_a[15:0] + mem_half;
	// Low word first, its carry feeds the high word
	assign dbl_lo = {1'b0, st_ff.general_register[odd_idx]} + {1'b0, st_ff.mdata_lo};
	assign dbl_hi = st_ff.general_register[even_idx] + st_ff.mdata_hi + {31'h00000000, dbl_lo[32]};
	assign res64 = {dbl_hi, dbl_lo[31:0]};
	assign ovf64 = (st_ff.general_register[even_idx][31] == st_ff.mdata_hi[31]) && (dbl_hi[31] != st_ff.general_register[even_idx][31]);

	// ==========================================================
	// Next state: register port, sequencer, interrupt flags
	always_comb
	begin
		logic [FPAS_IRQ_W-1:0] ev;
		logic [FPAS_IRQ_W-1:0] w1c;
		logic start;
		ev = '0;
		w1c = '0;
		start = 1'b0;
		nxt_st = st_ff;
		nxt_st.mem.rd = 1'b0;
		nxt_st.mem.wr = 1'b0;
		nxt_st.rdata = 32'h00000000;

		// Register writes; operand and program state is frozen while an operation runs
		if (I_BUS_REQ.wr)
		begin
			case (I_BUS_REQ.addr)
				FPAS_REG_PSW: if (!st_ff.busy) nxt_st.psw = I_BUS_REQ.wdata;
				FPAS_REG_INSTR: if (!st_ff.busy) nxt_st.instr = I_BUS_REQ.wdata;
				FPAS_REG_EADDR: if (!st_ff.busy) nxt_st.eaddr = I_BUS_REQ.wdata[23:0];
				FPAS_REG_CTRL: start = I_BUS_REQ.wdata[FPAS_CTRL_START_POS] & ~st_ff.busy;
				FPAS_REG_IRQ_STS: w1c = I_BUS_REQ.wdata[FPAS_IRQ_W-1:0];
				FPAS_REG_IRQ_MASK: nxt_st.mask = I_BUS_REQ.wdata[FPAS_IRQ_W-1:0];
				default:
				begin
					if (I_BUS_REQ.addr[7:5] == FPAS_REG_GPR_BASE[7:5] && I_BUS_REQ.addr[1:0] == 2'h0 && !st_ff.busy)
						nxt_st.general_register[I_BUS_REQ.addr[4:2]] = I_BUS_REQ.wdata;
				end
			endcase
		end

		// Register reads; unmapped offsets answer zero
		if (I_BUS_REQ.rd)
		begin
			case (I_BUS_REQ.addr)
				FPAS_REG_PSW: nxt_st.rdata = st_ff.psw;
				FPAS_REG_INSTR: nxt_st.rdata = st_ff.instr;
				FPAS_REG_EADDR: nxt_st.rdata = {8'h00, st_ff.eaddr};
				FPAS_REG_STAT: nxt_st.rdata = {27'h0000000, st_ff.op, st_ff.busy};
				FPAS_REG_IRQ_STS: nxt_st.rdata = {29'h00000000, st_ff.sts};
				FPAS_REG_IRQ_MASK: nxt_st.rdata = {29'h00000000, st_ff.mask};
				default:
				begin
					if (I_BUS_REQ.addr[7:5] == FPAS_REG_GPR_BASE[7:5] && I_BUS_REQ.addr[1:0] == 2'h0)
						nxt_st.rdata = st_ff.general_register[I_BUS_REQ.addr[4:2]];
				end
			endcase
		end

		// Sequencer
		case (st_ff.state)
			S_IDLE:
			begin
				if (start)
				begin
					nxt_st.op = dec_op;
					nxt_st.wsel = 1'b0;
					if (dec_op == OP_ILL)
						ev[FPAS_IRQ_ILL_POS] = 1'b1;
					else if (dec_op == OP_RR || dec_op == OP_RRM || dec_op == OP_ADD_IMM)
						nxt_st.state = S_EXEC;
					else
						nxt_st.state = S_READ;
				end
			end
			S_READ:
			begin
				// Doubleword reads the high word, then the word four bytes above
				nxt_st.mem.rd = 1'b1;
				nxt_st.mem.be = 4'hF;
				nxt_st.mem.addr = (st_ff.op == OP_ARD) ? {st_ff.eaddr[23:3], st_ff.wsel, 2'b00} : {st_ff.eaddr[23:2], 2'b00};
				nxt_st.state = S_WAIT;
			end
			S_WAIT:
			begin
				if (I_MEM_RSP.rvalid)
				begin
					if (st_ff.wsel)
						nxt_st.mdata_lo = I_MEM_RSP.rdata;
					else
						nxt_st.mdata_hi = I_MEM_RSP.rdata;
					if (st_ff.op == OP_ARD && !st_ff.wsel)
					begin
						nxt_st.wsel = 1'b1;
						nxt_st.state = S_READ;
					end
					else
						nxt_st.state = S_EXEC;
				end
			end
			S_EXEC:
			begin
				// Program counter: halfword for register forms, word otherwise
				nxt_st.psw[FPAS_PC_MSB:0] = pc_now + ((st_ff.op == OP_RR || st_ff.op == OP_RRM) ?
					FPAS_PC_STEP_SHORT : FPAS_PC_STEP_LONG);
				nxt_st.state = S_FIN;
				nxt_st.wsel = 1'b0;
				nxt_st.mem.addr = {st_ff.eaddr[23:2], 2'b00};
				case (st_ff.op)
					OP_RRM:
					begin
						nxt_st.general_register[rd_idx] = masked32;
						nxt_st.psw[FPAS_OVF_FLAG_POS:FPAS_ZERO_FLAG_POS] = fpas_cc(ovf32, masked32[31], masked32 == 32'h0);
						ev[FPAS_IRQ_OVF_POS] = ovf32;
					end
					OP_ARB:
					begin
						// Only one byte lane written; register untouched
						nxt_st.mem.wr = 1'b1;
						nxt_st.mem.wdata = {4{res32[7:0]}};
						nxt_st.mem.be = 4'h8 >> st_ff.eaddr[1:0];
						// Overflow, positive and negative are left cleared here
						nxt_st.psw[FPAS_OVF_FLAG_POS:FPAS_ZERO_FLAG_POS] = {3'b000, res32 == 32'h0};
					end
					OP_ARH:
					begin
						nxt_st.mem.wr = 1'b1;
						nxt_st.mem.wdata = {2{half_sum}};
						nxt_st.mem.be = st_ff.eaddr[1] ? 4'h3 : 4'hC;
						nxt_st.psw[FPAS_OVF_FLAG_POS:FPAS_ZERO_FLAG_POS] = {3'b000, half_sum == 16'h0};
					end
					OP_ARW:
					begin
						nxt_st.mem.wr = 1'b1;
						nxt_st.mem.wdata = res32;
						nxt_st.mem.be = 4'hF;
						nxt_st.psw[FPAS_OVF_FLAG_POS:FPAS_ZERO_FLAG_POS] = fpas_cc(ovf32, res32[31], res32 == 32'h0);
						ev[FPAS_IRQ_OVF_POS] = ovf32;
					end
					OP_ARD:
					begin
						// Low word goes out first, high word next cycle
						nxt_st.mem.wr = 1'b1;
						nxt_st.mem.addr = {st_ff.eaddr[23:3], 3'b100};
						nxt_st.mem.wdata = dbl_lo[31:0];
						nxt_st.mem.be = 4'hF;
						nxt_st.mdata_hi = dbl_hi;
						nxt_st.psw[FPAS_OVF_FLAG_POS:FPAS_ZERO_FLAG_POS] = fpas_cc(ovf64, res64[63], res64 == 64'h0);
						ev[FPAS_IRQ_OVF_POS] = ovf64;
						nxt_st.state = S_WRITE;
					end
					default:
					begin
						nxt_st.general_register[rd_idx] = res32;
						nxt_st.psw[FPAS_OVF_FLAG_POS:FPAS_ZERO_FLAG_POS] = fpas_cc(ovf32, res32[31], res32 == 32'h0);
						ev[FPAS_IRQ_OVF_POS] = ovf32;
					end
				endcase
			end
			S_WRITE:
			begin
				nxt_st.mem.wr = 1'b1;
				nxt_st.mem.addr = {st_ff.eaddr[23:3], 3'b000};
				nxt_st.mem.wdata = st_ff.mdata_hi;
				nxt_st.mem.be = 4'hF;
				nxt_st.state = S_FIN;
			end
			S_FIN:
			begin
				ev[FPAS_IRQ_DONE_POS] = 1'b1;
				nxt_st.state = S_IDLE;
			end
			default: nxt_st.state = S_IDLE;
		endcase

		// Sticky flags: a new event beats a same-cycle clear
		nxt_st.sts = (st_ff.sts & ~w1c) | ev;
		nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
		nxt_st.busy = (nxt_st.state != S_IDLE);
	end

	// ==========================================================
	// State register
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			st_ff <= FPAS_ST_RST;
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign O_BUS_RDATA = st_ff.rdata;
	assign O_MEM_REQ = st_ff.mem;
	assign O_IRQ = st_ff.irq;
	assign O_BUSY = st_ff.busy;

	// ==========================================================
	// Checks
	logic [31:0] h_rd_val;
	logic [31:0] h_rr_sum;
	logic [31:0] h_imm_sum;
	logic [31:0] h_subb;
	logic [7:0] h_res_lo8;
	logic h_dbl_zero;
	logic h_exec;

	assign h_rd_val = st_ff.general_register[rd_idx];
	assign h_rr_sum = st_ff.general_register[rd_idx] + st_ff.general_register[rs_idx];
	assign h_imm_sum = st_ff.general_register[rd_idx] + {{16{st_ff.instr[15]}}, st_ff.instr[15:0]};
	assign h_subb = st_ff.general_register[rd_idx] - {24'h000000, mem_byte};
	assign h_res_lo8 = res32[7:0];
	assign h_dbl_zero = (res64 == 64'h0);
	assign h_exec = (st_ff.state == S_EXEC);

	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	rr_add_a: assert property ((h_exec && st_ff.op == OP_RR) |=> h_rd_val == $past(h_rr_sum))
		else $error("register add result wrong");
	rr_mask_a: assert property ((h_exec && st_ff.op == OP_RRM) |=> h_rd_val == ($past(h_rr_sum) & $past(mask_val)))
		else $error("masked register add result wrong");
	cc_sign_a: assert property ((h_exec && (st_ff.op == OP_RR || st_ff.op == OP_ADD_IMM || st_ff.op == OP_SMB)) |=>
		st_ff.psw[FPAS_ZERO_FLAG_POS + 1] == h_rd_val[31] && st_ff.psw[FPAS_ZERO_FLAG_POS] == (h_rd_val == 32'h0)
		&& st_ff.psw[FPAS_OVF_FLAG_POS - 1] == (!h_rd_val[31] && h_rd_val != 32'h0))
		else $error("condition bits disagree with result");
	byte_lane_a: assert property ((st_ff.mem.wr && st_ff.op == OP_ARB) |->
		$onehot(st_ff.mem.be) && st_ff.mem.wdata[7:0] == $past(h_res_lo8))
		else $error("byte store lane or value wrong");
	byte_keep_a: assert property ((h_exec && st_ff.op == OP_ARB) |=> $stable(st_ff.general_register) ##1 st_ff.state == S_IDLE)
		else $error("byte add touched registers");
	byte_zero_a: assert property ((h_exec && st_ff.op == OP_ARB) |=> st_ff.psw[FPAS_ZERO_FLAG_POS] == ($past(res32) == 32'h0))
		else $error("byte add zero bit wrong");
	half_keep_a: assert property ((st_ff.mem.wr && st_ff.op == OP_ARH) |-> (st_ff.mem.be == 4'hC || st_ff.mem.be == 4'h3))
		else $error("halfword store enables wrong");
	half_zero_a: assert property ((st_ff.mem.wr && st_ff.op == OP_ARH) |->
		st_ff.psw[FPAS_ZERO_FLAG_POS] == (st_ff.mem.wdata[15:0] == 16'h0))
		else $error("halfword zero bit wrong");
	word_keep_a: assert property ((h_exec && st_ff.op == OP_ARW) |=> $stable(st_ff.general_register) && st_ff.mem.wr && st_ff.mem.be == 4'hF)
		else $error("word add to memory misbehaved");
	dbl_order_a: assert property ((st_ff.mem.wr && st_ff.op == OP_ARD && st_ff.mem.addr[2]) |=>
		st_ff.mem.wr && !st_ff.mem.addr[2])
		else $error("doubleword store order wrong");
	dbl_zero_a: assert property ((h_exec && st_ff.op == OP_ARD) |=> st_ff.psw[FPAS_ZERO_FLAG_POS] == $past(h_dbl_zero))
		else $error("doubleword zero bit wrong");
	imm_add_a: assert property ((h_exec && st_ff.op == OP_ADD_IMM) |=> h_rd_val == $past(h_imm_sum))
		else $error("immediate add result wrong");
	sub_byte_a: assert property ((h_exec && st_ff.op == OP_SMB) |=> h_rd_val == $past(h_subb))
		else $error("byte subtract result wrong");
	pc_step_a: assert property ((h_exec && st_ff.op == OP_RR) |=> pc_now == $past(pc_now) + FPAS_PC_STEP_SHORT)
		else $error("program counter step wrong");
	// Done must land even when software clears the flags in the same cycle
	irq_level_a: assert property ((st_ff.state == S_FIN) |=> st_ff.sts[FPAS_IRQ_DONE_POS]
		&& (O_IRQ || !st_ff.mask[FPAS_IRQ_DONE_POS]))
		else $error("done flag or interrupt level wrong");

	rr_done_c: cover property ((h_exec && st_ff.op == OP_RR) ##2 st_ff.sts[FPAS_IRQ_DONE_POS]);
	dbl_write_c: cover property (st_ff.mem.wr && st_ff.op == OP_ARD ##1 st_ff.mem.wr);
	irq_rise_c: cover property ($rose(O_IRQ));

endmodule : fpas_top

//--- tb/fpas_mem_model.sv
// Behavioural memory that answers the datapath's operand port.
// Assumes word-aligned byte addresses and no more than one read outstanding.
`timescale 1ns/100ps
module fpas_mem_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_lat,
	input wire fpas_pkg::fpas_mem_req_type i_req,
	output fpas_pkg::fpas_mem_rsp_type o_rsp
);
	import fpas_pkg::*;
	// ==========================================
	// Storage and read timing
	logic [31:0] mem [0:63];
	logic [3:0] cnt_ff;
	logic [5:0] idx_ff;
	// Read data is inverted when idle, so a stale word is never mistaken for an answer
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_ff <= 4'h0;
			o_rsp <= '0;
		end
		else
		begin
			// Answer once the count runs out; otherwise keep toggling the idle data
			o_rsp.rvalid <= !i_req.rd && cnt_ff == 4'h1;
			o_rsp.rdata <= (!i_req.rd && cnt_ff == 4'h1) ? mem[idx_ff] : ~o_rsp.rdata;
			if (i_req.rd)
			begin
				cnt_ff <= i_lat;
				idx_ff <= i_req.addr[7:2];
			end
			else if (cnt_ff != 4'h0)
				cnt_ff <= cnt_ff - 4'h1;
			// Only enabled lanes change; the others must survive
			if (i_req.wr)
				for (int b = 0; b < 4; b++)
					if (i_req.be[b])
						mem[i_req.addr[7:2]][8*b+:8] <= i_req.wdata[8*b+:8];
		end
	end
endmodule : fpas_mem_model

//--- tb/test_fpas_top.sv
// Self-checking bench for the add/subtract datapath.
// Assumes the memory model above on the operand port and register access only when idle.
`timescale 1ns/100ps
module test_fpas_top;
	import fpas_pkg::*;
	// ==========================================
	// Signals and instances
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	fpas_bus_req_type req = '0;
	logic [31:0] rdata;
	fpas_mem_req_type mreq;
	fpas_mem_rsp_type mrsp;
	logic irq;
	logic busy;
	logic [3:0] lat = 4'h1;
	logic [23:0] pc = 24'h0;
	int n_mismatch = 0;
	int comparisons = 0;
	always #4 clk = ~clk;
	fpas_top i_fpas_top (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_BUS_REQ(req), .O_BUS_RDATA(rdata),
		.O_MEM_REQ(mreq), .I_MEM_RSP(mrsp), .O_IRQ(irq), .O_BUSY(busy));
	fpas_mem_model i_fpas_mem_model (.i_clk(clk), .i_rst_n(arst_n), .i_lat(lat), .i_req(mreq), .o_rsp(mrsp));
	// ==========================================
	// Shared tasks
	task report_and_stop;
		$display("Checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask : wr
	// Read data stands only in the cycle after the strobe, so it is sampled there
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
	endtask : rd
	task cg(input string nm, input int n, input logic [31:0] e);
		logic [31:0] d;
		rd(8'(4 * n), d);
		chk(nm, e, d);
	endtask : cg
	function logic [31:0] ins(logic [5:0] o, logic [2:0] r, logic [2:0] s, logic f, logic [2:0] u,
		logic [15:0] i);
		return {o, r, s, f, u, i};
	endfunction : ins
	function logic [3:0] ccf(logic [31:0] r, logic v);
		return {v, ~r[31] & (r != 32'h0), r[31], r == 32'h0};
	endfunction : ccf
	// Starts one instruction, waits a bounded time, then checks the status word
	task run(input logic [31:0] iw, input logic [7:0] ea, input logic [23:0] st, input logic [3:0] cc,
		input logic [3:0] m);
		logic [31:0] d;
		int n;
		wr(FPAS_REG_INSTR, iw);
		wr(FPAS_REG_EADDR, {24'h0, ea});
		wr(FPAS_REG_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		#1 n = 0;
		while (busy !== 1'b0 && n < 60)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 60)
		begin
			$display("FAIL busy expected 0 seen 1");
			n_mismatch++;
			report_and_stop();
		end
		pc = pc + st;
		rd(FPAS_REG_PSW, d);
		chk("psw", {1'b0, cc & m, 3'h0, pc}, d & {1'b1, m, 27'h7FFFFFF});
	endtask : run
	// ==========================================
	// Scenarios
	task t_rr;
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'h18, 32'hFF03C67D);
		wr(8'h1C, 32'h045C6E3F);
		run(ins(FPAS_OPC_RR, 6, 7, 0, 0, 0), 0, FPAS_PC_STEP_SHORT, 4'h4, 4'hF);
		cg("gpr6", 6, 32'h036034BC);
		wr(8'h04, 32'h7FFFFFFF);
		wr(8'h08, 32'h1);
		run(ins(FPAS_OPC_RR, 1, 2, 0, 0, 0), 0, FPAS_PC_STEP_SHORT, 4'hA, 4'hF);
		cg("gpr1", 1, 32'h80000000);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(FPAS_REG_IRQ_MASK, 32'h2);
		#1 chk("irq raised", 32'h1, {31'h0, irq});
		wr(FPAS_REG_IRQ_STS, 32'h7);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
		cg("unmapped", 15, 32'h0);
		$display("Test rr finished");
	endtask : t_rr
	task t_rrm;
		wr(8'h10, 32'h007FFFFC);
		wr(8'h18, 32'h004FC276);
		wr(8'h1C, 32'h0037C1F3);
		run(ins(FPAS_OPC_RR, 6, 7, 1, 0, 0), 0, FPAS_PC_STEP_SHORT, 4'h4, 4'hF);
		cg("gpr6", 6, 32'h00078468);
		$display("Test rrm finished");
	endtask : t_rrm
	task t_arw;
		lat = 4'h4;
		i_fpas_mem_model.mem[16] = 32'h11111111;
		wr(8'h1C, 32'h245C6E3F);
		run(ins(FPAS_OPC_ARM, 7, 0, 0, 0, 0), 8'h40, FPAS_PC_STEP_LONG, 4'h4, 4'hF);
		chk("mem word", 32'h356D7F50, i_fpas_mem_model.mem[16]);
		cg("gpr7", 7, 32'h245C6E3F);
		$display("Test arw finished");
	endtask : t_arw
	// Zero is judged on the full sum, not on the stored byte
	task t_arb;
		i_fpas_mem_model.mem[17] = 32'hAA10BBCC;
		wr(8'h18, 32'hFFFFFFF0);
		run(ins(FPAS_OPC_ARM, 6, 0, 1, 0, 0), 8'h45, FPAS_PC_STEP_LONG, 4'h1, 4'h1);
		chk("mem byte", 32'hAA00BBCC, i_fpas_mem_model.mem[17]);
		cg("gpr6", 6, 32'hFFFFFFF0);
		wr(8'h18, 32'h00000100);
		run(ins(FPAS_OPC_ARM, 6, 0, 1, 0, 0), 8'h45, FPAS_PC_STEP_LONG, 4'h0, 4'h1);
		chk("mem byte", 32'hAA00BBCC, i_fpas_mem_model.mem[17]);
		$display("Test arb finished");
	endtask : t_arb
	task t_arh;
		lat = 4'h1;
		i_fpas_mem_model.mem[18] = 32'h123403BE;
		wr(8'h14, 32'hFFFFFC42);
		run(ins(FPAS_OPC_ARM, 5, 0, 0, 0, 1), 8'h4A, FPAS_PC_STEP_LONG, 4'h1, 4'h1);
		chk("mem half", 32'h12340000, i_fpas_mem_model.mem[18]);
		cg("gpr5", 5, 32'hFFFFFC42);
		$display("Test arh finished");
	endtask : t_arh
	// Low word sums to zero with a carry; the 64-bit result is still positive
	task t_ard;
		lat = 4'h3;
		i_fpas_mem_model.mem[20] = 32'h3869A07E;
		i_fpas_mem_model.mem[21] = 32'h0EA439C2;
		wr(8'h18, 32'h01A298A1);
		wr(8'h1C, 32'hF15BC63E);
		run(ins(FPAS_OPC_ARM, 6, 0, 0, 0, 2), 8'h50, FPAS_PC_STEP_LONG, 4'h4, 4'hF);
		chk("mem high", 32'h3A0C3920, i_fpas_mem_model.mem[20]);
		chk("mem low", 32'h0, i_fpas_mem_model.mem[21]);
		cg("gpr7", 7, 32'hF15BC63E);
		$display("Test ard finished");
	endtask : t_ard
	task t_add_imm;
		wr(8'h00, 32'h0000794E);
		run(ins(FPAS_OPC_IMM, 0, 0, 0, FPAS_SUBOP_ADD_IMM, 16'h86B2), 0, FPAS_PC_STEP_LONG, 4'h1, 4'hF);
		cg("gpr0", 0, 32'h0);
		$display("Test add_imm finished");
	endtask : t_add_imm
	// Byte with top bit set must not be sign-extended; halfword must be
	task t_sub;
		i_fpas_mem_model.mem[24] = 32'hFFFFFF9A;
		i_fpas_mem_model.mem[26] = 32'hFFFE1234;
		wr(8'h04, 32'h0194A7F2);
		run(ins(FPAS_OPC_SUM, 1, 0, 1, 0, 0), 8'h63, FPAS_PC_STEP_LONG, 4'h4, 4'hF);
		cg("gpr1", 1, 32'h0194A758);
		wr(8'h18, 32'h00024CB3);
		run(ins(FPAS_OPC_SUM, 6, 0, 0, 0, 1), 8'h68, FPAS_PC_STEP_LONG, ccf(32'h00024CB5, 0), 4'hF);
		cg("gpr6", 6, 32'h00024CB5);
		$display("Test sub finished");
	endtask : t_sub
	// An opcode outside this block raises the illegal flag and never starts
	task t_ill;
		wr(FPAS_REG_IRQ_STS, 32'h7);
		wr(FPAS_REG_INSTR, ins(6'h00, 1, 2, 0, 0, 0));
		wr(FPAS_REG_CTRL, 32'h1);
		#1 chk("busy", 32'h0, {31'h0, busy});
		cg("irq sts", 13, 32'h4);
		cg("stat", 12, 32'h0000001E);
		$display("Test ill finished");
	endtask : t_ill
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_rr();
		t_rrm();
		t_arw();
		t_arb();
		t_arh();
		t_ard();
		t_add_imm();
		t_sub();
		t_ill();
		report_and_stop();
	end
endmodule : test_fpas_top
